/* File: verilog/ccdo_pkg.sv */
// package: operation codes, widths and constants for the clear/compare/decrement datapath
package ccdo_pkg;
    localparam int CCDO_DATA_W = 8;
    localparam int CCDO_ADDR_W = 6;
    localparam logic [7:0] CCDO_ZERO = 8'h00;
    localparam logic [7:0] CCDO_ONE = 8'h01;
    localparam logic CCDO_DEST_WORK = 1'b0;
    localparam logic CCDO_DEST_FILE = 1'b1;

    typedef enum logic [2:0]
    {
        CCDO_OP_NONE,
        CCDO_OP_CLEAR_WORKING,
        CCDO_OP_CLEAR_WATCHDOG,
        CCDO_OP_CLEAR_FILE,
        CCDO_OP_COMPLEMENT_FILE,
        CCDO_OP_COMPARE,
        CCDO_OP_MINUS_ONE
    } ccdo_op_e;

    // one instruction as issued by the decoder
    typedef struct packed {
        logic valid;
        ccdo_op_e op;
        logic result_target_bit;
        logic [5:0] file_addr;
        logic [7:0] file_data;
        logic [7:0] working_in;
    } ccdo_req_s;

    // registered results
    typedef struct packed {
        logic [7:0] working_register;
        logic working_we;
        logic [7:0] file_wdata;
        logic [5:0] file_waddr;
        logic file_we;
        logic result_nil_flag;
        logic borrow_not_flag;
        logic watchdog_expiry_flag;
        logic power_down_flag;
        logic watchdog_clear;
        logic divider_clear;
        logic done;
    } ccdo_state_s;
endpackage

/* File: verilog/ccdo_datapath.sv */
// module: single-cycle execution datapath for clear, complement, compare and decrement
`timescale 1ns/10ps
// Behaviour
// - clear working op loads 00h into working register, sets nil flag, one cycle.
// - clear watchdog op clears watchdog, and shared divider when assigned to it.
// - clear watchdog op sets expiry and power-down flags, nothing else changes.
// - clear file op writes 00h to addressed slot and sets nil flag.
// - complement op inverts slot, routes by target bit, updates nil flag.
// - target bit 0 sends result to working register, 1 back to slot.
// - compare computes slot minus working register, updates nil and borrow-not flags.
// - compare discards difference, working register and slot unchanged, one cycle.
// - minus one op decrements slot, routes by target bit, updates only nil flag.
module ccdo_datapath
    import ccdo_pkg::*;
(
    input wire logic core_clk, // core instruction clock
    input wire logic rst_n, // synchronous reset, active low
    input wire ccdo_req_s req, // decoded instruction and operands
    input wire logic divider_to_watchdog, // shared divider assigned to watchdog
    input wire logic nil_in, // current nil flag
    input wire logic borrow_not_in, // current borrow-not flag
    input wire logic expiry_in, // current watchdog expiry flag
    input wire logic power_down_in, // current power-down flag
    output logic [7:0] working_register, // working register value
    output logic working_we, // working register written this cycle
    output logic [7:0] file_wdata, // file slot write data
    output logic [5:0] file_waddr, // file slot write address
    output logic file_we, // file slot write strobe
    output logic result_nil_flag, // nil flag
    output logic borrow_not_flag, // borrow-not flag
    output logic watchdog_expiry_flag, // watchdog expiry flag
    output logic power_down_flag, // power-down flag
    output logic watchdog_clear, // pulse clearing watchdog counter
    output logic divider_clear, // pulse clearing shared divider
    output logic done // instruction completed
);
    ccdo_state_s s_q;
    ccdo_state_s s_d;

    function automatic logic is_nil(input logic [7:0] v);
        is_nil = (v == CCDO_ZERO);
    endfunction

    // ***************************
    // next state
    // ***************************
    logic [8:0] diff;
    logic [7:0] res;
    always_comb
    begin
        // ninth bit of the difference is the borrow out
        diff = {1'b0, req.file_data} - {1'b0, req.working_in};
        res = CCDO_ZERO;
        // write data holds between strobes; the core only looks at it under a strobe
        s_d = s_q;
        s_d.working_we = 1'b0;
        s_d.file_we = 1'b0;
        s_d.watchdog_clear = 1'b0;
        s_d.divider_clear = 1'b0;
        s_d.done = 1'b0;
        s_d.file_waddr = req.file_addr;
        // flags follow the core's copies unless an op changes them
        s_d.result_nil_flag = nil_in;
        s_d.borrow_not_flag = borrow_not_in;
        s_d.watchdog_expiry_flag = expiry_in;
        s_d.power_down_flag = power_down_in;
        if (req.valid)
        begin
            s_d.done = 1'b1;
            case (req.op)
                CCDO_OP_CLEAR_WORKING:
                begin
                    s_d.working_register = CCDO_ZERO;
                    s_d.working_we = 1'b1;
                    s_d.result_nil_flag = 1'b1;
                end
                CCDO_OP_CLEAR_WATCHDOG:
                begin
                    s_d.watchdog_clear = 1'b1;
                    s_d.divider_clear = divider_to_watchdog;
                    s_d.watchdog_expiry_flag = 1'b1;
                    s_d.power_down_flag = 1'b1;
                end
                CCDO_OP_CLEAR_FILE:
                begin
                    s_d.file_wdata = CCDO_ZERO;
                    s_d.file_we = 1'b1;
                    s_d.result_nil_flag = 1'b1;
                end
                CCDO_OP_COMPLEMENT_FILE, CCDO_OP_MINUS_ONE:
                begin
                    if (req.op == CCDO_OP_COMPLEMENT_FILE)
                        res = ~req.file_data;
                    else
                        res = req.file_data - CCDO_ONE;
                    s_d.result_nil_flag = is_nil(res);
                    if (req.result_target_bit == CCDO_DEST_FILE)
                    begin
                        s_d.file_wdata = res;
                        s_d.file_we = 1'b1;
                    end
                    else
                    begin
                        s_d.working_register = res;
                        s_d.working_we = 1'b1;
                    end
                end
                CCDO_OP_COMPARE:
                begin
                    // difference only feeds flags; no write strobe raised
                    s_d.result_nil_flag = is_nil(diff[7:0]);
                    s_d.borrow_not_flag = ~diff[8];
                end
                default:
                begin
                    s_d.done = 1'b0;
                end
            endcase
        end
    end

    // one reset edge clears every output, strobes included
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign working_register = s_q.working_register;
    assign working_we = s_q.working_we;
    assign file_wdata = s_q.file_wdata;
    assign file_waddr = s_q.file_waddr;
    assign file_we = s_q.file_we;
    assign result_nil_flag = s_q.result_nil_flag;
    assign borrow_not_flag = s_q.borrow_not_flag;
    assign watchdog_expiry_flag = s_q.watchdog_expiry_flag;
    assign power_down_flag = s_q.power_down_flag;
    assign watchdog_clear = s_q.watchdog_clear;
    assign divider_clear = s_q.divider_clear;
    assign done = s_q.done;

    // ***************************
    // assertions
    // ***************************
    sequence s_issue(ccdo_op_e o);
        req.valid && req.op == o;
    endsequence

    // routing step of the two write-back ops
    sequence s_dest(logic t);
        req.result_target_bit == t;
    endsequence

    a_clear_work_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_issue(CCDO_OP_CLEAR_WORKING) |=> working_we && working_register == CCDO_ZERO
            && result_nil_flag)
        else $error("clear working op result wrong");
    a_clear_work_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_issue(CCDO_OP_CLEAR_WORKING) |=> !file_we
            && borrow_not_flag == $past(borrow_not_in))
        else $error("clear working op touched other state");
    a_wdt_clear_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_issue(CCDO_OP_CLEAR_WATCHDOG) |=> watchdog_clear
            && divider_clear == $past(divider_to_watchdog)
            ##1 watchdog_clear == ($past(req.valid) && $past(req.op) == CCDO_OP_CLEAR_WATCHDOG))
        else $error("watchdog clear pulse wrong");
    a_wdt_only_op: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(req.valid && req.op == CCDO_OP_CLEAR_WATCHDOG)
            |=> !watchdog_clear && !divider_clear)
        else $error("watchdog clear without its op");
    a_wdt_flags_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_issue(CCDO_OP_CLEAR_WATCHDOG) |=> watchdog_expiry_flag && power_down_flag
            && !file_we && !working_we && result_nil_flag == $past(nil_in)
            && borrow_not_flag == $past(borrow_not_in))
        else $error("watchdog clear flags wrong");
    a_clear_file_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_issue(CCDO_OP_CLEAR_FILE) |=> file_we && file_wdata == CCDO_ZERO && result_nil_flag
            && file_waddr == $past(req.file_addr))
        else $error("clear file op result wrong");
    a_clear_file_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_issue(CCDO_OP_CLEAR_FILE) |=> !working_we
            && working_register == $past(working_register))
        else $error("clear file op touched working register");
    a_comp_route: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_issue(CCDO_OP_COMPLEMENT_FILE) ##0 s_dest(CCDO_DEST_FILE) |=> file_we
            && file_wdata == ~$past(req.file_data)
            && result_nil_flag == (file_wdata == CCDO_ZERO))
        else $error("complement result wrong");
    a_comp_work: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_issue(CCDO_OP_COMPLEMENT_FILE) ##0 s_dest(CCDO_DEST_WORK)
            |=> working_register == ~$past(req.file_data)
            && result_nil_flag == (working_register == CCDO_ZERO))
        else $error("complement to working register wrong");
    a_target_work: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_issue(CCDO_OP_COMPLEMENT_FILE) or s_issue(CCDO_OP_MINUS_ONE))
            ##0 s_dest(CCDO_DEST_WORK) |=> working_we && !file_we)
        else $error("target bit zero misrouted");
    a_cmp_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_issue(CCDO_OP_COMPARE) |=> borrow_not_flag == ($past(req.file_data)
            >= $past(req.working_in)) && result_nil_flag == ($past(req.file_data)
            == $past(req.working_in)))
        else $error("compare flags wrong");
    a_cmp_no_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_issue(CCDO_OP_COMPARE) |=> !file_we && !working_we && done)
        else $error("compare wrote a result");
    a_cmp_keep_work: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_issue(CCDO_OP_COMPARE)
            |=> working_register == $past(working_register))
        else $error("compare changed working register");
    a_dec_value: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_issue(CCDO_OP_MINUS_ONE) |=> borrow_not_flag == $past(borrow_not_in)
            && result_nil_flag == ($past(req.file_data) == CCDO_ONE))
        else $error("minus one flags wrong");
    a_dec_file: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_issue(CCDO_OP_MINUS_ONE) ##0 s_dest(CCDO_DEST_FILE) |=> file_we && !working_we
            && file_wdata == $past(req.file_data) - CCDO_ONE)
        else $error("minus one to slot wrong");
    a_dec_work: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_issue(CCDO_OP_MINUS_ONE) ##0 s_dest(CCDO_DEST_WORK)
            |=> working_register == $past(req.file_data) - CCDO_ONE)
        else $error("minus one to working register wrong");
    a_waddr_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
        file_waddr == $past(req.file_addr))
        else $error("slot address not carried");
endmodule // ccdo_datapath

/* File: verif/test_clear_compare_decrement_ops.sv */
// testbench: random and corner-case checks of the clear/compare/decrement datapath
`timescale 1ns/10ps
module test_clear_compare_decrement_ops
    import ccdo_pkg::*;
;
    logic core_clk, rst_n, div_wd;
    logic [3:0] fl; // nil, borrow-not, expiry, power-down
    ccdo_req_s req, r;
    wire ccdo_state_s got;
    logic [7:0] exp_work;
    logic [31:0] rnd;
    int errors, n_checks;

    ccdo_datapath ccdo_datapath_i (.core_clk(core_clk), .rst_n(rst_n), .req(req),
        .divider_to_watchdog(div_wd), .nil_in(fl[3]), .borrow_not_in(fl[2]),
        .expiry_in(fl[1]), .power_down_in(fl[0]),
        .working_register(got.working_register), .working_we(got.working_we),
        .file_wdata(got.file_wdata), .file_waddr(got.file_waddr), .file_we(got.file_we),
        .result_nil_flag(got.result_nil_flag), .borrow_not_flag(got.borrow_not_flag),
        .watchdog_expiry_flag(got.watchdog_expiry_flag), .power_down_flag(got.power_down_flag),
        .watchdog_clear(got.watchdog_clear), .divider_clear(got.divider_clear), .done(got.done));

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ************************************************************
    // expectation model
    // ************************************************************
    function automatic ccdo_state_s model(ccdo_req_s q, logic dw, logic [3:0] f, logic [7:0] wk);
        ccdo_state_s e;
        logic [7:0] res;
        e = '0;
        e.working_register = wk;
        e.file_waddr = q.file_addr;
        {e.result_nil_flag, e.borrow_not_flag, e.watchdog_expiry_flag, e.power_down_flag} = f;
        res = (q.op == CCDO_OP_COMPLEMENT_FILE) ? ~q.file_data : q.file_data - CCDO_ONE;
        if (q.valid)
        begin
            e.done = (q.op != CCDO_OP_NONE);
            case (q.op)
                CCDO_OP_CLEAR_WORKING:
                begin
                    e.working_register = CCDO_ZERO;
                    e.working_we = 1'b1;
                    e.result_nil_flag = 1'b1;
                end
                CCDO_OP_CLEAR_WATCHDOG:
                begin
                    e.watchdog_clear = 1'b1;
                    e.divider_clear = dw;
                    e.watchdog_expiry_flag = 1'b1;
                    e.power_down_flag = 1'b1;
                end
                CCDO_OP_CLEAR_FILE:
                begin
                    e.file_we = 1'b1;
                    e.file_wdata = CCDO_ZERO;
                    e.result_nil_flag = 1'b1;
                end
                CCDO_OP_COMPARE:
                begin
                    res = q.file_data - q.working_in;
                    e.result_nil_flag = (res == CCDO_ZERO);
                    e.borrow_not_flag = (q.file_data >= q.working_in);
                end
                CCDO_OP_COMPLEMENT_FILE, CCDO_OP_MINUS_ONE:
                begin
                    e.result_nil_flag = (res == CCDO_ZERO);
                    e.file_we = (q.result_target_bit == CCDO_DEST_FILE);
                    e.file_wdata = e.file_we ? res : CCDO_ZERO;
                    e.working_we = !e.file_we;
                    e.working_register = e.file_we ? wk : res;
                end
                default:;
            endcase
        end
        return e;
    endfunction

    // ************************************************************
    // drivers and comparison
    // ************************************************************
    task automatic check(ccdo_state_s g, ccdo_state_s e);
        // write data is don't-care while no write strobe
        if (e.file_we !== 1'b1)
            g.file_wdata = e.file_wdata;
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic step(ccdo_req_s q, logic dw, logic [3:0] f);
        ccdo_state_s e;
        req = q;
        div_wd = dw;
        fl = f;
        e = model(q, dw, f, exp_work);
        @(negedge core_clk);
        check(got, e);
        exp_work = e.working_register;
    endtask

    function automatic ccdo_req_s mk(ccdo_op_e op, logic t, logic [7:0] fd, logic [7:0] wi);
        return '{1'b1, op, t, 6'h2a, fd, wi};
    endfunction

    task automatic do_reset;
        rst_n = 1'b0;
        req = '0;
        repeat (3) @(negedge core_clk);
        check(got, '0);
        rst_n = 1'b1;
        exp_work = CCDO_ZERO;
        @(negedge core_clk);
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        rst_n = 1'b0;
        req = '0;
        div_wd = 1'b0;
        fl = 4'h0;
        errors = 0;
        n_checks = 0;
        rnd = $urandom(32'hebfa);
        do_reset;
        step(mk(CCDO_OP_MINUS_ONE, 1'b1, 8'h01, 8'h77), 1'b0, 4'h0);
        step(mk(CCDO_OP_MINUS_ONE, 1'b0, 8'h00, 8'h77), 1'b0, 4'hf);
        step(mk(CCDO_OP_COMPLEMENT_FILE, 1'b1, 8'ha6, 8'h00), 1'b0, 4'h8);
        step(mk(CCDO_OP_COMPLEMENT_FILE, 1'b0, 8'hff, 8'h00), 1'b0, 4'h0);
        step(mk(CCDO_OP_COMPARE, 1'b0, 8'h34, 8'h12), 1'b0, 4'h8);
        step(mk(CCDO_OP_COMPARE, 1'b1, 8'h12, 8'h34), 1'b0, 4'h4);
        step(mk(CCDO_OP_COMPARE, 1'b0, 8'h5a, 8'h5a), 1'b0, 4'h0);
        step(mk(CCDO_OP_CLEAR_WORKING, 1'b0, 8'h55, 8'h55), 1'b0, 4'h0);
        step(mk(CCDO_OP_CLEAR_FILE, 1'b0, 8'h55, 8'h21), 1'b0, 4'h4);
        step(mk(CCDO_OP_CLEAR_WATCHDOG, 1'b0, 8'h00, 8'h00), 1'b0, 4'ha);
        step(mk(CCDO_OP_CLEAR_WATCHDOG, 1'b0, 8'h00, 8'h00), 1'b1, 4'h4);
        r = mk(CCDO_OP_CLEAR_WORKING, 1'b0, 8'h10, 8'h10);
        r.valid = 1'b0;
        step(r, 1'b1, 4'h5);
        step(mk(CCDO_OP_NONE, 1'b1, 8'h00, 8'h00), 1'b1, 4'h0);
        for (int i = 0; i < 1500; i++)
        begin
            rnd = $urandom;
            r = rnd[26:0];
            r.op = ccdo_op_e'($urandom_range(6));
            r.valid = ($urandom_range(7) != 0);
            rnd = $urandom;
            step(r, rnd[4], rnd[3:0]);
            if (i == 900)
                do_reset;
        end
        end_of_test;
    end
endmodule // test_clear_compare_decrement_ops
